// ==== hdl/asr_pkg.sv ====
// constants for the static memory host controller
`default_nettype none
package asr_pkg;
  localparam int unsigned ADDR_W       = 13;
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CLK_PERIOD_NS = 20;
  // slowest grade figures, so any grade is met
  localparam int unsigned READ_CYCLE_NS   = 85;
  localparam int unsigned WRITE_PULSE_NS  = 65;
  localparam int unsigned DATA_SETUP_NS   = 35;
  localparam int unsigned HIZ_NS          = 35;
  // least times round up
  localparam int unsigned READ_CYC  =
    (READ_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_CYC =
    (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned SETUP_CYC =
    (DATA_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned HIZ_CYC   =
    (HIZ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_SETUP = 5'h02,
    ST_WRITE = 5'h04,
    ST_READ  = 5'h08,
    ST_TURN  = 5'h10
  } asr_state_t;
endpackage
`default_nettype wire

// ==== hdl/asr_timer.sv ====
// down counter that pulses when a loaded count has run out
`timescale 1ns/100ps
`default_nettype none
module asr_timer
(
  input  wire logic                          i_clk,
  input  wire logic                          i_resetn,
  input  wire logic                          i_load,
  input  wire logic [asr_pkg::CNT_W-1:0]     i_count,
  output logic                               o_done
);
  logic [asr_pkg::CNT_W-1:0] cnt_reg;
  logic [asr_pkg::CNT_W-1:0] cnt_next;
  logic                      done_reg;
  logic                      done_next;

  // ------------------------------------------------------------
  // count next value
  // ------------------------------------------------------------
  always_comb
  begin
    cnt_next  = cnt_reg;
    done_next = 1'b0;
    if (i_load)
    begin
      cnt_next = i_count;
    end
    else if (cnt_reg != asr_pkg::CNT_ZERO)
    begin
      cnt_next  = cnt_reg - asr_pkg::CNT_ONE;
      done_next = (cnt_reg == asr_pkg::CNT_ONE);
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      cnt_reg  <= '0;
      done_reg <= 1'b0;
    end
    else
    begin
      cnt_reg  <= cnt_next;
      done_reg <= done_next;
    end
  end

  assign o_done = done_reg;
endmodule
`default_nettype wire

// ==== hdl/asr_host.sv ====
// host controller driving an 8k x 8 asynchronous static memory
`timescale 1ns/100ps
`default_nettype none
module asr_host
(
  input  wire logic                          i_clk,
  input  wire logic                          i_resetn,
  input  wire logic                          i_req,
  input  wire logic                          i_we,
  input  wire logic [asr_pkg::ADDR_W-1:0]    i_addr,
  input  wire logic [asr_pkg::DATA_W-1:0]    i_wdata,
  output logic                               o_busy,
  output logic                               o_done,
  output logic [asr_pkg::DATA_W-1:0]         o_rdata,
  output logic [asr_pkg::ADDR_W-1:0]         o_mem_addr,
  output logic                               o_chip_select_low_n,
  output logic                               o_chip_select_high,
  output logic                               o_out_en_n,
  output logic                               o_write_n,
  output logic [asr_pkg::DATA_W-1:0]         o_data,
  output logic                               o_data_oe,
  input  wire logic [asr_pkg::DATA_W-1:0]    i_data
);
  asr_pkg::asr_state_t         st_reg;
  asr_pkg::asr_state_t         st_next;
  logic [asr_pkg::ADDR_W-1:0]  addr_reg;
  logic [asr_pkg::ADDR_W-1:0]  addr_next;
  logic [asr_pkg::DATA_W-1:0]  wd_reg;
  logic [asr_pkg::DATA_W-1:0]  wd_next;
  logic [asr_pkg::DATA_W-1:0]  rd_reg;
  logic [asr_pkg::DATA_W-1:0]  rd_next;
  logic                        csl_n_reg;
  logic                        csl_n_next;
  logic                        csh_reg;
  logic                        csh_next;
  logic                        oe_n_reg;
  logic                        oe_n_next;
  logic                        we_n_reg;
  logic                        we_n_next;
  logic                        doe_reg;
  logic                        doe_next;
  logic                        busy_reg;
  logic                        busy_next;
  logic                        done_reg;
  logic                        done_next;
  logic                        tload;
  logic [asr_pkg::CNT_W-1:0]   tcount;
  logic                        tdone;

  // ------------------------------------------------------------
  // phase timer
  // ------------------------------------------------------------
  asr_timer u_timer
  (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_load   (tload),
    .i_count  (tcount),
    .o_done   (tdone)
  );

  // ------------------------------------------------------------
  // sequencer next state
  // ------------------------------------------------------------
  always_comb
  begin
    st_next    = st_reg;
    addr_next  = addr_reg;
    wd_next    = wd_reg;
    rd_next    = rd_reg;
    csl_n_next = csl_n_reg;
    csh_next   = csh_reg;
    oe_n_next  = oe_n_reg;
    we_n_next  = we_n_reg;
    doe_next   = doe_reg;
    busy_next  = busy_reg;
    done_next  = 1'b0;
    tload      = 1'b0;
    tcount     = asr_pkg::CNT_ZERO;
    unique case (st_reg)
      asr_pkg::ST_IDLE:
      begin
        if (i_req)
        begin
          // address moves only while deselected and strobe high
          addr_next = i_addr;
          wd_next   = i_wdata;
          busy_next = 1'b1;
          tload     = 1'b1;
          if (i_we)
          begin
            // strobe falls with select so outputs never turn on
            st_next    = asr_pkg::ST_WRITE;
            csl_n_next = 1'b0;
            csh_next   = 1'b1;
            we_n_next  = 1'b0;
            doe_next   = 1'b1;
            tcount     = asr_pkg::CNT_W'(asr_pkg::WRITE_CYC);
          end
          else
          begin
            // address loads on the same edge that select falls
            st_next    = asr_pkg::ST_READ;
            csl_n_next = 1'b0;
            csh_next   = 1'b1;
            oe_n_next  = 1'b0;
            tcount     = asr_pkg::CNT_W'(asr_pkg::READ_CYC);
          end
        end
      end
      asr_pkg::ST_WRITE:
      begin
        if (tdone)
        begin
          // select and strobe rise together; data held two more cycles
          st_next    = asr_pkg::ST_SETUP;
          csl_n_next = 1'b1;
          we_n_next  = 1'b1;
          tload      = 1'b1;
          tcount     = asr_pkg::CNT_ONE;
        end
      end
      asr_pkg::ST_SETUP:
      begin
        if (tdone)
        begin
          // hold after the first rising edge satisfied, now release
          st_next   = asr_pkg::ST_IDLE;
          doe_next  = 1'b0;
          csh_next  = 1'b0;
          busy_next = 1'b0;
          done_next = 1'b1;
        end
      end
      asr_pkg::ST_READ:
      begin
        if (tdone)
        begin
          // sample late in the cycle, strobe stays high throughout
          rd_next    = i_data;
          st_next    = asr_pkg::ST_TURN;
          csl_n_next = 1'b1;
          csh_next   = 1'b0;
          oe_n_next  = 1'b1;
          tload      = 1'b1;
          tcount     = asr_pkg::CNT_W'(asr_pkg::HIZ_CYC);
        end
      end
      asr_pkg::ST_TURN:
      begin
        // wait for the memory to float before anyone drives the bus
        if (tdone)
        begin
          st_next   = asr_pkg::ST_IDLE;
          busy_next = 1'b0;
          done_next = 1'b1;
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // state registers; pins idle deselected and floating
  // ------------------------------------------------------------
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      st_reg    <= asr_pkg::ST_IDLE;
      addr_reg  <= '0;
      wd_reg    <= '0;
      rd_reg    <= '0;
      csl_n_reg <= 1'b1;
      csh_reg   <= 1'b0;
      oe_n_reg  <= 1'b1;
      we_n_reg  <= 1'b1;
      doe_reg   <= 1'b0;
      busy_reg  <= 1'b0;
      done_reg  <= 1'b0;
    end
    else
    begin
      st_reg    <= st_next;
      addr_reg  <= addr_next;
      wd_reg    <= wd_next;
      rd_reg    <= rd_next;
      csl_n_reg <= csl_n_next;
      csh_reg   <= csh_next;
      oe_n_reg  <= oe_n_next;
      we_n_reg  <= we_n_next;
      doe_reg   <= doe_next;
      busy_reg  <= busy_next;
      done_reg  <= done_next;
    end
  end

  assign o_busy              = busy_reg;
  assign o_done              = done_reg;
  assign o_rdata             = rd_reg;
  assign o_mem_addr          = addr_reg;
  assign o_chip_select_low_n = csl_n_reg;
  assign o_chip_select_high  = csh_reg;
  assign o_out_en_n          = oe_n_reg;
  assign o_write_n           = we_n_reg;
  assign o_data              = wd_reg;
  assign o_data_oe           = doe_reg;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  chk_strobe_in_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !oe_n_reg |-> we_n_reg)
    else $error("write strobe low while output enabled");
  chk_addr_stable: assert property (@(posedge i_clk) disable iff (!i_resetn)
    (!csl_n_reg && !we_n_reg) |=> $stable(addr_reg) || csl_n_reg)
    else $error("address moved during write overlap");
  chk_bus_free_read: assert property (@(posedge i_clk) disable iff (!i_resetn)
    !oe_n_reg |-> !doe_reg)
    else $error("host drives data while memory may");
  chk_write_len: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(we_n_reg) |-> !we_n_reg [*5] ##1 we_n_reg)
    else $error("write pulse length wrong");
  chk_write_end: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $rose(we_n_reg) |-> csl_n_reg && doe_reg)
    else $error("write end or data hold wrong");
  chk_select_fall: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(csl_n_reg) |-> csh_reg ##1 $stable(addr_reg))
    else $error("select fall without stable address");
  chk_strobe_order: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(we_n_reg) |-> $fell(csl_n_reg))
    else $error("strobe fell after select");
  chk_read_sel: assert property (@(posedge i_clk) disable iff (!i_resetn)
    $fell(oe_n_reg) |-> !csl_n_reg [*6] ##1 csl_n_reg)
    else $error("read select window wrong");
endmodule
`default_nettype wire

// ==== verification/asr_sram_model.sv ====
// behavioural 8k x 8 static memory facing the host controller
`timescale 1ns/100ps
`default_nettype none
module asr_sram_model
#(
  parameter int HOLD_NS = 85
)
(
  input  wire logic [12:0] i_addr,
  input  wire logic        i_csl_n,
  input  wire logic        i_csh,
  input  wire logic        i_oe_n,
  input  wire logic        i_we_n,
  input  wire logic [7:0]  i_bus,
  input  wire logic [7:0]  i_acc_ns,
  output logic      [7:0]  o_q,
  output logic             o_q_oe
);
  logic [7:0]  mem [0:8191];
  logic [7:0]  lat_d;
  logic [12:0] lat_a;
  logic        sel;
  logic        wr_act;
  logic        ready;
  logic        active_pwr;
  realtime     t_chg;
  realtime     t_wake;
  // ----------------------------------------
  // storage and write window
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 8192; i++)
      mem[i] = 8'(i) ^ 8'ha5;
  end
  assign sel    = !i_csl_n && i_csh;
  assign wr_act = sel && !i_we_n;
  // latch during overlap, commit when the first of select, high select or strobe ends it
  always @*
  begin
    if (wr_act)
    begin
      lat_d = i_bus;
      lat_a = i_addr;
    end
  end
  always @(negedge wr_act) mem[lat_a] = lat_d;
  // ----------------------------------------
  // read path, slow or prompt by access time
  // ----------------------------------------
  always @(i_addr, sel) t_chg = $realtime;
  always #1 ready = ($realtime - t_chg) >= i_acc_ns;
  assign o_q_oe = sel && !i_oe_n && i_we_n;
  // stale data is inverted so an early sample never passes by luck
  assign o_q    = ready ? mem[i_addr] : ~mem[i_addr];
  // ----------------------------------------
  // power state, dropped on its own after hold
  // ----------------------------------------
  // wake on selection itself, so select and high select moving in one
  // step cannot race the decode
  always @(posedge sel, negedge i_we_n, i_addr)
    if (sel) t_wake = $realtime;
  always @(i_bus)
    if (wr_act) t_wake = $realtime;
  always #1 active_pwr = ($realtime - t_wake) < HOLD_NS;
endmodule
`default_nettype wire

// ==== verification/asr_host_bench.sv ====
// self-checking bench for the static memory host controller
`timescale 1ns/100ps
`default_nettype none
module asr_host_bench;
  logic        clk    = 1'b0;
  logic        resetn = 1'b0;
  logic        req    = 1'b0;
  logic        we     = 1'b0;
  logic [12:0] addr   = 13'h0000;
  logic [7:0]  wdata  = 8'h00;
  logic [7:0]  acc_ns = 8'h0a;
  logic [7:0]  flt    = 8'h5a;
  logic        p_rst  = 1'b0;
  logic [7:0]  rdata, hdata, q, bus, p_data;
  logic [12:0] m_addr, p_addr, ra;
  logic        busy, done, csl_n, csh, oe_n, we_n, hoe, q_oe;
  logic        p_csl_n, p_we_n, p_wr;
  logic [7:0]  shadow [0:8191];
  int          n_fail, check_count, cyc;
  always #10 clk = ~clk;
  // undriven bus shows a pattern that changes every cycle
  always @(posedge clk) flt <= ~flt;
  assign bus = hoe ? hdata : (q_oe ? q : flt);
  asr_host DUT (.i_clk(clk), .i_resetn(resetn), .i_req(req), .i_we(we),
    .i_addr(addr), .i_wdata(wdata), .o_busy(busy), .o_done(done),
    .o_rdata(rdata), .o_mem_addr(m_addr), .o_chip_select_low_n(csl_n),
    .o_chip_select_high(csh), .o_out_en_n(oe_n), .o_write_n(we_n),
    .o_data(hdata), .o_data_oe(hoe), .i_data(bus));
  asr_sram_model mem_i (.i_addr(m_addr), .i_csl_n(csl_n), .i_csh(csh),
    .i_oe_n(oe_n), .i_we_n(we_n), .i_bus(bus), .i_acc_ns(acc_ns),
    .o_q(q), .o_q_oe(q_oe));
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // bus watch between edges, skipped around reset
  always @(negedge clk)
  begin
    if (resetn && p_rst)
    begin
      check(16'(hoe & q_oe), 16'h0);
      if (!oe_n) check(16'(we_n), 16'h1);
      if (m_addr !== p_addr) check(16'(p_csl_n | p_we_n), 16'h1);
      if (p_wr) check({7'h0, hoe, hdata}, {8'h1, p_data});
      if (p_we_n && !we_n) check(16'(p_csl_n), 16'h1);
      if (!p_we_n && we_n) check(16'(csl_n), 16'h1);
    end
    {p_rst, p_addr, p_csl_n, p_we_n, p_data} = {resetn, m_addr, csl_n,
                                                 we_n, hdata};
    p_wr = !csl_n && csh && !we_n;
  end
  // hang guard, far above the fewer than a thousand cycles needed
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      n_fail++;
      wrap_up();
    end
  end
  // one transfer; stray inputs while busy must be ignored
  task automatic xfer(input logic w, input logic [12:0] a,
                      input logic [7:0] d, input int hold);
    int n;
    @(posedge clk);
    req <= 1'b1;
    we <= w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    addr <= ~a;
    wdata <= ~d;
    if (hold == 0) req <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
      if (n == hold) req <= 1'b0;
      if (n == 2) check({m_addr, csl_n, csh, we_n}, {a, 2'b01, ~w});
      if (n == 2) check(16'(mem_i.active_pwr), 16'h1);
    end
    // done is seen one edge after it is raised; the registered timer adds
    // a cycle to each phase, and a read also waits for the bus to float
    if (w) check(16'(n), 16'(asr_pkg::WRITE_CYC + 4));
    else check(16'(n), 16'(asr_pkg::READ_CYC + asr_pkg::HIZ_CYC + 3));
    // memory has dropped to idle power well before the answer
    check(16'(mem_i.active_pwr), 16'h0);
    if (w) shadow[a] = d;
    else check(16'(rdata), 16'(shadow[a]));
  endtask
  task automatic idle_check();
    @(negedge clk);
    check({csl_n, csh, oe_n, we_n, hoe, busy, done}, 7'h58);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    for (int i = 0; i < 8192; i++)
      shadow[i] = 8'(i) ^ 8'ha5;
    void'($urandom(32'hcb54));
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    idle_check();
    check(16'(rdata), 16'h0);
    $display("test reset done");
    // boundary addresses and data, with a held request
    xfer(1'b1, 13'h0000, 8'h00, 3);
    xfer(1'b1, 13'h1fff, 8'hff, 0);
    xfer(1'b0, 13'h0000, 8'h00, 3);
    xfer(1'b0, 13'h1fff, 8'h00, 0);
    xfer(1'b0, 13'h1ffe, 8'h00, 0);
    $display("test corners done");
    // random traffic, memory alternating slow and prompt
    for (int k = 0; k < 60; k++)
    begin
      @(posedge clk);
      acc_ns <= k[0] ? 8'h4b : 8'h0a;
      ra = 13'($urandom % 64);
      xfer(1'($urandom), ra, 8'($urandom), int'($urandom % 4));
    end
    $display("test random done");
    // reset in the middle of a write, then recover
    @(posedge clk);
    req <= 1'b1;
    we <= 1'b1;
    addr <= 13'h0aaa;
    wdata <= 8'h3c;
    @(posedge clk);
    req <= 1'b0;
    repeat (3) @(posedge clk);
    resetn <= 1'b0;
    idle_check();
    @(posedge clk);
    resetn <= 1'b1;
    idle_check();
    xfer(1'b1, 13'h0aaa, 8'hc3, 0);
    xfer(1'b0, 13'h0aaa, 8'h00, 0);
    $display("test abort done");
    wrap_up();
  end
endmodule
`default_nettype wire
